//--- btr_consts.vh
// Constants shared by the branch trace recorder files
`ifndef BTR_CONSTS_VH
`define BTR_CONSTS_VH

// ****************************************
// Register addresses on the register access port
// ****************************************
`define BTR_ADDR_W 12
`define BTR_CTRL_ADDR 12'h000
`define BTR_TOS_ADDR 12'h001
`define BTR_FROM_BASE 12'h010
`define BTR_TO_BASE 12'h020

// ****************************************
// Trace control fields
// ****************************************
`define BTR_BIT_REC 0
`define BTR_BIT_STEP 1
`define BTR_BIT_MSG 2
`define BTR_BIT_STORE 3
`define BTR_BIT_INT 4
`define BTR_BIT_SKIP0 5
`define BTR_BIT_SKIPU 6
`define BTR_CTRL_W 7
`define BTR_CTRL_RESET 7'h00

// ****************************************
// Feature identification flags
// ****************************************
`define BTR_FEAT_STORE_BIT 21
`define BTR_FEAT_CPL_BIT 4
`define BTR_FEAT_EDX 32'h00200000
`define BTR_FEAT_ECX 32'h00000010

// ****************************************
// Record stack and message buffer sizes
// ****************************************
`define BTR_SMALL_DEPTH 4
`define BTR_SMALL_PTRW 2
`define BTR_LARGE_DEPTH 16
`define BTR_LARGE_PTRW 4
`define BTR_FIFO_DEPTH 16
`define BTR_FIFO_AW 4
`define BTR_REC_SHIFT 3

`endif

//--- btr_fifo.v
// Message buffer between record capture and the bus and store drains
`timescale 1ns/1ps
`default_nettype none
module btr_fifo #(
  parameter WIDTH = 66,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Fill level
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign level = count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop)
      begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end
      else if (pop && !push)
      begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // btr_fifo
`default_nettype wire

//--- btr_sink.sv
// System bus and trace buffer partner that takes messages and store writes
`timescale 1ns/1ps
`default_nettype none
module btr_sink (
  // Clock, reset and stall control
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  // Trace messages and store writes
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [63:0] msg_data,
  input wire logic store_valid,
  output logic store_ready,
  input wire logic [31:0] store_addr,
  input wire logic [63:0] store_data
);
  logic [1:0] cnt;
  logic [63:0] mq[$];
  logic [95:0] sq[$];
  // Stalls on the two channels are out of step so completions interleave
  always @(posedge mclk)
  begin
    cnt <= reset ? 2'h0 : cnt + 2'h1;
    msg_ready <= !reset && (!slow || cnt == 2'h3);
    store_ready <= !reset && (!slow || cnt == 2'h1);
    if (!reset && msg_valid && msg_ready) mq.push_back(msg_data);
    if (!reset && store_valid && store_ready) sq.push_back({store_addr, store_data});
  end
endmodule // btr_sink
`default_nettype wire

//--- btr_stack.v
// Circular record stack with top-of-stack pointer
`timescale 1ns/1ps
`default_nettype none
module btr_stack #(
  parameter DEPTH = 16,
  parameter PTRW = 4,
  parameter PAIRED = 1
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Record write
  input wire wr_en,
  input wire [31:0] wr_from,
  input wire [31:0] wr_to,
  // Read access
  input wire [PTRW-1:0] rd_idx,
  output wire [31:0] rd_from,
  output wire [31:0] rd_to,
  output wire [PTRW-1:0] top_of_stack_pointer
);
  reg [PTRW-1:0] ptr;
  wire [PTRW-1:0] next_ptr;

  // Natural overflow of the pointer width gives the wrap to zero
  assign next_ptr = ptr + {{(PTRW-1){1'b0}}, 1'b1};
  assign top_of_stack_pointer = ptr;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      ptr <= {PTRW{1'b0}};
    end
    else if (wr_en)
    begin
      ptr <= next_ptr;
    end
  end

  generate
    if (PAIRED != 0)
    begin : g_pairs
      reg [31:0] from_mem [0:DEPTH-1];
      reg [31:0] to_mem [0:DEPTH-1];
      always @(posedge mclk)
      begin
        if (wr_en)
        begin
          from_mem[next_ptr] <= wr_from;
          to_mem[next_ptr] <= wr_to;
        end
      end
      assign rd_from = from_mem[rd_idx];
      assign rd_to = to_mem[rd_idx];
    end
    else
    begin : g_single
      reg [63:0] rec_mem [0:DEPTH-1];
      always @(posedge mclk)
      begin
        if (wr_en)
        begin
          rec_mem[next_ptr] <= {wr_to, wr_from};
        end
      end
      assign rd_from = rec_mem[rd_idx][31:0];
      assign rd_to = rec_mem[rd_idx][63:32];
    end
  endgenerate
endmodule // btr_stack
`default_nettype wire

//--- btr_top.v
// Branch trace recorder: control register, record stack, trace messages and store
`include "btr_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module btr_top #(
  parameter STACK_LARGE = 1
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register access port
  input wire reg_wr,
  input wire reg_rd,
  input wire [`BTR_ADDR_W-1:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire [1:0] cur_cpl,
  input wire real_mode,
  output reg [63:0] reg_rdata,
  output reg reg_done,
  output reg reg_fault,
  // Control transfer events from the core
  input wire ev_valid,
  output reg ev_ready,
  input wire [31:0] ev_from,
  input wire [31:0] ev_to,
  input wire ev_cpl0,
  input wire ev_trap,
  input wire [31:0] ev_trap_to,
  // Single-step control
  input wire retire_valid,
  input wire retire_taken,
  input wire trap_flag,
  input wire debug_exception,
  output reg step_trap,
  // Trace messages to the system bus
  output reg msg_valid,
  input wire msg_ready,
  output reg [63:0] msg_data,
  // Trace store writes into the debug save area
  input wire [31:0] store_base,
  input wire [15:0] store_size,
  output reg store_valid,
  input wire store_ready,
  output reg [31:0] store_addr,
  output reg [63:0] store_data,
  output reg buffer_full_irq,
  // Feature identification results
  output reg [31:0] feature_edx,
  output reg [31:0] feature_ecx
);
  // ****************************************
  // Configuration
  // ****************************************
  localparam DEPTH = (STACK_LARGE != 0) ? `BTR_LARGE_DEPTH : `BTR_SMALL_DEPTH;
  localparam PTRW = (STACK_LARGE != 0) ? `BTR_LARGE_PTRW : `BTR_SMALL_PTRW;
  localparam FW = 66;
  localparam [`BTR_FIFO_AW:0] READY_LIMIT = 5'h0D;
  localparam S_IDLE = 1'b0;
  localparam S_BUSY = 1'b1;

  // True when addr falls inside the stack window starting at base
  function in_window;
    input [`BTR_ADDR_W-1:0] addr;
    input [`BTR_ADDR_W-1:0] base;
    begin
      in_window = (addr >= base) && (addr < base + DEPTH[`BTR_ADDR_W-1:0]);
    end
  endfunction

  // ****************************************
  // Trace control register
  // ****************************************
  reg [`BTR_CTRL_W-1:0] ctrl;
  wire rec_en = ctrl[`BTR_BIT_REC];
  wire step_br = ctrl[`BTR_BIT_STEP];
  wire msg_en = ctrl[`BTR_BIT_MSG];
  wire store_en = ctrl[`BTR_BIT_STORE];
  wire int_en = ctrl[`BTR_BIT_INT];
  wire skip0 = ctrl[`BTR_BIT_SKIP0];
  wire skipu = ctrl[`BTR_BIT_SKIPU];

  wire priv_ok = (cur_cpl == 2'h0) || real_mode;
  wire wr_ctrl = reg_wr && (reg_addr == `BTR_CTRL_ADDR) && priv_ok;
  wire step_fire = retire_valid && trap_flag && (!step_br || retire_taken);
  wire dbg_clear = debug_exception || step_fire;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl <= `BTR_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl <= reg_wdata[`BTR_CTRL_W-1:0];
      end
      // A debug exception in the same cycle as a write still freezes recording
      if (dbg_clear)
      begin
        ctrl[`BTR_BIT_REC] <= 1'b0;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      step_trap <= 1'b0;
    end
    else
    begin
      step_trap <= step_fire;
    end
  end

  // ****************************************
  // Record sequencing
  // ****************************************
  reg pending;
  reg [31:0] pend_from;
  reg [31:0] pend_to;
  reg pend_cpl0;
  wire ev_take = ev_valid && ev_ready;
  wire rec_valid = ev_take || pending;
  wire [31:0] rec_from = pending ? pend_from : ev_from;
  wire [31:0] rec_to = pending ? pend_to : ev_to;
  wire rec_cpl0 = pending ? pend_cpl0 : ev_cpl0;
  wire next_pending = ev_take && ev_trap;

  always @(posedge mclk)
  begin
    if (reset)
    begin
      pending <= 1'b0;
      pend_from <= 32'h00000000;
      pend_to <= 32'h00000000;
      pend_cpl0 <= 1'b0;
    end
    else
    begin
      // The exception record follows one cycle after the branch record
      pending <= next_pending;
      if (next_pending)
      begin
        pend_from <= ev_from;
        pend_to <= ev_trap_to;
        pend_cpl0 <= ev_cpl0;
      end
    end
  end

  // ****************************************
  // Record stack
  // ****************************************
  wire [31:0] stk_from;
  wire [31:0] stk_to;
  wire [PTRW-1:0] top_of_stack_pointer;
  wire [PTRW-1:0] rd_idx;
  wire from_hit = in_window(reg_addr, `BTR_FROM_BASE);
  wire to_hit = in_window(reg_addr, `BTR_TO_BASE);
  wire [`BTR_ADDR_W-1:0] from_off = reg_addr - `BTR_FROM_BASE;
  wire [`BTR_ADDR_W-1:0] to_off = reg_addr - `BTR_TO_BASE;
  assign rd_idx = from_hit ? from_off[PTRW-1:0] : to_off[PTRW-1:0];

  btr_stack #(
    .DEPTH(DEPTH),
    .PTRW(PTRW),
    .PAIRED(STACK_LARGE)
  ) u_stack (
    .mclk(mclk),
    .reset(reset),
    .wr_en(rec_valid && rec_en),
    .wr_from(rec_from),
    .wr_to(rec_to),
    .rd_idx(rd_idx),
    .rd_from(stk_from),
    .rd_to(stk_to),
    .top_of_stack_pointer(top_of_stack_pointer)
  );

  // ****************************************
  // Message filtering and buffering
  // ****************************************
  wire filtered = (rec_cpl0 && skip0) || (!rec_cpl0 && skipu);
  wire want_msg = msg_en && !filtered;
  wire want_store = store_en && !filtered;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire [`BTR_FIFO_AW:0] fifo_level;
  reg state;
  wire head_take = (state == S_IDLE) && fifo_out_valid;

  btr_fifo #(
    .WIDTH(FW),
    .DEPTH(`BTR_FIFO_DEPTH),
    .AW(`BTR_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(rec_valid && (want_msg || want_store)),
    .in_ready(fifo_in_ready),
    .in_data({want_msg, want_store, rec_to, rec_from}),
    .out_valid(fifo_out_valid),
    .out_ready(head_take),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Ready is registered, so it keeps room for the pushes made while it is stale
  always @(posedge mclk)
  begin
    if (reset)
    begin
      ev_ready <= 1'b0;
    end
    else
    begin
      ev_ready <= !next_pending && fifo_in_ready && (fifo_level < READY_LIMIT);
    end
  end

  // ****************************************
  // Bus and store drain
  // ****************************************
  reg [15:0] store_idx;
  wire [15:0] next_idx = store_idx + 16'h0001;
  wire store_take = store_valid && store_ready;
  wire wrap_point = (next_idx >= store_size);
  wire full_set = store_take && wrap_point && int_en;
  wire [31:0] idx_bytes = {13'h0000, store_idx, 3'h0};

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      msg_valid <= 1'b0;
      msg_data <= 64'h0000000000000000;
      store_valid <= 1'b0;
      store_addr <= 32'h00000000;
      store_data <= 64'h0000000000000000;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (head_take)
          begin
            msg_valid <= fifo_out_data[65];
            msg_data <= fifo_out_data[63:0];
            // While stopped on a full buffer the store copy is dropped
            store_valid <= fifo_out_data[64] && !buffer_full_irq;
            store_addr <= store_base + idx_bytes;
            store_data <= fifo_out_data[63:0];
            state <= S_BUSY;
          end
        end
        S_BUSY:
        begin
          if (msg_valid && msg_ready)
          begin
            msg_valid <= 1'b0;
          end
          if (store_take)
          begin
            store_valid <= 1'b0;
          end
          if ((!msg_valid || msg_ready) && (!store_valid || store_ready))
          begin
            state <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      store_idx <= 16'h0000;
      buffer_full_irq <= 1'b0;
    end
    else
    begin
      if (store_take)
      begin
        if (wrap_point)
        begin
          store_idx <= 16'h0000;
        end
        else
        begin
          store_idx <= next_idx;
        end
      end
      else if (wr_ctrl)
      begin
        store_idx <= 16'h0000;
      end
      // A fill in the same cycle as the rearming write keeps the flag set
      if (full_set)
      begin
        buffer_full_irq <= 1'b1;
      end
      else if (wr_ctrl)
      begin
        buffer_full_irq <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register reads, refused writes, features
  // ****************************************
  reg [63:0] next_rdata;
  reg rd_ok;

  always @*
  begin
    next_rdata = 64'h0000000000000000;
    rd_ok = 1'b1;
    if (reg_addr == `BTR_CTRL_ADDR)
    begin
      next_rdata[`BTR_CTRL_W-1:0] = ctrl;
    end
    else if (reg_addr == `BTR_TOS_ADDR)
    begin
      next_rdata[PTRW-1:0] = top_of_stack_pointer;
    end
    else if (from_hit)
    begin
      if (STACK_LARGE != 0)
      begin
        next_rdata[31:0] = stk_from;
      end
      else
      begin
        next_rdata = {stk_to, stk_from};
      end
    end
    else if (to_hit)
    begin
      next_rdata[31:0] = stk_to;
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      reg_rdata <= 64'h0000000000000000;
      reg_done <= 1'b0;
      reg_fault <= 1'b0;
    end
    else
    begin
      reg_done <= reg_rd || reg_wr;
      if (reg_rd)
      begin
        reg_rdata <= rd_ok ? next_rdata : 64'h0000000000000000;
        reg_fault <= !rd_ok;
      end
      else
      begin
        // Stack and pointer writes are refused, as is an unprivileged write
        reg_fault <= reg_wr && !wr_ctrl;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      feature_edx <= `BTR_FEAT_EDX;
      feature_ecx <= `BTR_FEAT_ECX;
    end
    else
    begin
      feature_edx <= `BTR_FEAT_EDX;
      feature_ecx <= `BTR_FEAT_ECX;
    end
  end
endmodule // btr_top
`default_nettype wire

//--- btr_top_properties.sv
// Port checks for the branch trace recorder, bound to its top module
`include "btr_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module btr_properties (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [`BTR_ADDR_W-1:0] reg_addr,
  input wire logic [1:0] cur_cpl,
  input wire logic real_mode,
  input wire logic reg_done,
  input wire logic reg_fault,
  // Events, stepping, messages and store
  input wire logic ev_valid,
  input wire logic ev_ready,
  input wire logic ev_trap,
  input wire logic retire_valid,
  input wire logic retire_taken,
  input wire logic trap_flag,
  input wire logic step_trap,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [63:0] msg_data,
  input wire logic store_valid,
  input wire logic store_ready,
  input wire logic [31:0] store_addr
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // A trap event needs a second cycle for its exception record
  sequence s_trap_take;
    ev_valid && ev_ready && ev_trap;
  endsequence
  sequence s_ctrl_wr;
    reg_wr && reg_addr == `BTR_CTRL_ADDR;
  endsequence
  AST_PRIV_REFUSE: assert property (s_ctrl_wr ##0 (cur_cpl != 2'h0 && !real_mode)
    |=> reg_done && reg_fault) else $error("unprivileged control write accepted");
  AST_PRIV_TAKE: assert property (s_ctrl_wr ##0 (cur_cpl == 2'h0 || real_mode)
    |=> reg_done && !reg_fault) else $error("privileged control write refused");
  AST_RO_REGS: assert property (reg_wr && reg_addr != `BTR_CTRL_ADDR |=> reg_fault)
    else $error("write to read-only register not refused");
  AST_STEP_TAKEN: assert property (retire_valid && trap_flag && retire_taken |=> step_trap)
    else $error("no step trap on taken branch");
  AST_STEP_IDLE: assert property (!(retire_valid && trap_flag) |=> !step_trap)
    else $error("step trap without a qualifying retire");
  AST_TRAP_PAIR: assert property (s_trap_take |=> !ev_ready)
    else $error("trap event not given a second record cycle");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data))
    else $error("trace message dropped or changed while waiting");
  AST_STORE_HOLD: assert property (store_valid && !store_ready |=> store_valid && $stable(store_addr))
    else $error("store write dropped or moved while waiting");
endmodule // btr_properties
bind btr_top btr_properties i_btr_properties (.mclk, .reset, .reg_wr, .reg_addr, .cur_cpl,
  .real_mode, .reg_done, .reg_fault, .ev_valid, .ev_ready, .ev_trap, .retire_valid,
  .retire_taken, .trap_flag, .step_trap, .msg_valid, .msg_ready, .msg_data, .store_valid,
  .store_ready, .store_addr);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the branch trace recorder
`include "btr_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, reset, reg_wr, reg_rd, real_mode, reg_done, reg_fault, ev_valid, ev_ready;
  logic ev_cpl0, ev_trap, retire_valid, retire_taken, trap_flag, debug_exception, step_trap;
  logic msg_valid, msg_ready, store_valid, store_ready, buffer_full_irq, slow, mirq;
  logic [1:0] cur_cpl;
  logic [6:0] ctl;
  logic [11:0] reg_addr;
  logic [15:0] store_size;
  logic [31:0] ev_from, ev_to, ev_trap_to, store_base, store_addr, feature_edx, feature_ecx;
  logic [31:0] r, mf[16], mt[16];
  logic [63:0] reg_wdata, reg_rdata, msg_data, store_data, s_rdata, em[$];
  logic [95:0] es[$];
  integer n_mismatch, total_checks, seed, cyc, i, j, k, top_of_stack_pointer, idx, sj;
  btr_top #(.STACK_LARGE(1)) i_btr_top (.mclk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .cur_cpl, .real_mode, .reg_rdata, .reg_done, .reg_fault, .ev_valid,
    .ev_ready, .ev_from, .ev_to, .ev_cpl0, .ev_trap, .ev_trap_to, .retire_valid,
    .retire_taken, .trap_flag, .debug_exception, .step_trap, .msg_valid, .msg_ready,
    .msg_data, .store_base, .store_size, .store_valid, .store_ready, .store_addr,
    .store_data, .buffer_full_irq, .feature_edx, .feature_ecx);
  btr_sink i_btr_sink (.mclk, .reset, .slow, .msg_valid, .msg_ready, .msg_data,
    .store_valid, .store_ready, .store_addr, .store_data);
  // Four-entry build on the same stimulus; its record flow matches, so only reads are compared
  btr_top #(.STACK_LARGE(0)) i_btr_top_small (.mclk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .cur_cpl, .real_mode, .reg_rdata(s_rdata), .reg_done(), .reg_fault(),
    .ev_valid, .ev_ready(), .ev_from, .ev_to, .ev_cpl0, .ev_trap, .ev_trap_to, .retire_valid,
    .retire_taken, .trap_flag, .debug_exception, .step_trap(), .msg_valid(), .msg_ready,
    .msg_data(), .store_base, .store_size, .store_valid(), .store_ready, .store_addr(),
    .store_data(), .buffer_full_irq(), .feature_edx(), .feature_ecx());
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000) n_mismatch = n_mismatch + 1;
    if (cyc == 30000) report_and_stop();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) n_mismatch = n_mismatch + 1;
    if (got !== exp) $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // For a read, d is the expected read data
  task automatic rop(input logic w, input logic [11:0] a, input logic [63:0] d, input logic f);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({62'h0, reg_done, reg_fault}, {62'h1, f});
    if (!w) chk(reg_rdata, d);
  endtask
  task automatic wctl(input logic [63:0] d);
    rop(1'b1, `BTR_CTRL_ADDR, d, 1'b0);
    ctl = d[6:0];
    idx = 0;
    mirq = 1'b0;
  endtask
  task automatic rec(input logic [31:0] t);
    if (ctl[0]) top_of_stack_pointer = (top_of_stack_pointer + 1) % 16;
    if (ctl[0]) mf[top_of_stack_pointer] = ev_from;
    if (ctl[0]) mt[top_of_stack_pointer] = t;
    if ((ctl[5] && ev_cpl0) || (ctl[6] && !ev_cpl0)) return;
    if (ctl[2]) em.push_back({t, ev_from});
    if (ctl[3] && !mirq) es.push_back({store_base + 32'(idx * 8), t, ev_from});
    if (ctl[3] && !mirq) idx = (idx + 1 >= store_size) ? 0 : idx + 1;
    if (ctl[3] && !mirq && idx == 0) mirq = ctl[4];
  endtask
  // Event held until taken; the model follows once it is in
  task automatic ev(input logic tr);
    r = $random(seed);
    @(posedge mclk);
    ev_valid <= 1'b1;
    ev_from <= $random(seed);
    ev_to <= $random(seed);
    ev_trap_to <= $random(seed);
    ev_cpl0 <= r[0];
    ev_trap <= tr;
    @(negedge mclk);
    while (ev_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    ev_valid <= 1'b0;
    rec(ev_to);
    if (tr) rec(ev_trap_to);
  endtask
  task automatic stk();
    rop(1'b0, `BTR_TOS_ADDR, 64'(top_of_stack_pointer), 1'b0);
    chk(s_rdata, 64'(top_of_stack_pointer % 4));
    for (k = 0; k < 16; k++)
    begin
      rop(1'b0, `BTR_FROM_BASE + 12'(k), {32'h0, mf[k]}, 1'b0);
      // The four-entry stack keeps the newest record of each pointer value mod 4
      sj = (top_of_stack_pointer + 16 - (top_of_stack_pointer + 16 - k) % 4) % 16;
      if (k < 4) chk(s_rdata, {mt[sj], mf[sj]});
      rop(1'b0, `BTR_TO_BASE + 12'(k), {32'h0, mt[k]}, 1'b0);
    end
  endtask
  task automatic drain();
    for (i = 0; i < 400; i++)
      if (i_btr_sink.mq.size() < em.size() || i_btr_sink.sq.size() < es.size()) @(posedge mclk);
    // Let records queued behind the last expected one leave, and outputs settle off the edge
    repeat (6) @(negedge mclk);
    chk(64'(i_btr_sink.mq.size()), 64'(em.size()));
    chk(64'(i_btr_sink.sq.size()), 64'(es.size()));
    foreach (em[n]) chk(i_btr_sink.mq[n], em[n]);
    foreach (es[n]) chk(i_btr_sink.sq[n][95:32], es[n][95:32]);
    foreach (es[n]) chk(i_btr_sink.sq[n][63:0], es[n][63:0]);
    em.delete();
    es.delete();
    i_btr_sink.mq.delete();
    i_btr_sink.sq.delete();
  endtask
  task automatic step(input logic tk, input logic dbg, input logic ex);
    @(posedge mclk);
    retire_valid <= !dbg;
    retire_taken <= tk;
    debug_exception <= dbg;
    @(posedge mclk);
    retire_valid <= 1'b0;
    debug_exception <= 1'b0;
    @(negedge mclk);
    chk({63'h0, step_trap}, {63'h0, ex});
    if (ex || dbg) ctl[0] = 1'b0;
  endtask
  initial
  begin
    {reg_wr, reg_rd, real_mode, ev_valid, ev_cpl0, ev_trap, retire_valid, retire_taken} = '0;
    {trap_flag, debug_exception, slow, mirq, ctl} = '0;
    {reg_addr, reg_wdata, cur_cpl, ev_from, ev_to, ev_trap_to, store_base} = '0;
    {n_mismatch, total_checks, cyc, top_of_stack_pointer, idx} = '0;
    store_size = 16'h0003;
    seed = 32'h09333aad;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rop(1'b0, `BTR_CTRL_ADDR, 64'h0, 1'b0);
    chk({feature_ecx, feature_edx}, 64'h00000010_00200000);
    rop(1'b0, `BTR_TOS_ADDR, 64'h0, 1'b0);
    r = $random(seed);
    wctl({r, r & 32'hFFFF_FF80} | 64'h55);
    rop(1'b0, `BTR_CTRL_ADDR, 64'h55, 1'b0);
    @(posedge mclk);
    cur_cpl <= 2'h3;
    rop(1'b1, `BTR_CTRL_ADDR, 64'h0, 1'b1);
    rop(1'b0, `BTR_CTRL_ADDR, 64'h55, 1'b0);
    @(posedge mclk);
    real_mode <= 1'b1;
    wctl(64'h0);
    @(posedge mclk);
    real_mode <= 1'b0;
    cur_cpl <= 2'h0;
    rop(1'b1, `BTR_TOS_ADDR, 64'h5, 1'b1);
    rop(1'b1, `BTR_FROM_BASE, 64'h5, 1'b1);
    rop(1'b0, 12'h3FF, 64'h0, 1'b1);
    $display("test registers done");
    wctl(64'h1);
    for (j = 0; j < 18; j++) ev(1'b0);
    stk();
    ev(1'b1);
    stk();
    wctl(64'h0);
    ev(1'b0);
    stk();
    $display("test stack done");
    r = $random(seed);
    @(posedge mclk);
    store_base <= {r[31:3], 3'h0};
    for (j = 0; j < 3; j++)
    begin
      slow <= j != 1;
      wctl(64'h0C + 64'(j) * 64'h20);
      for (i = 0; i < 6; i++) ev(i == 3);
      drain();
    end
    $display("test messages done");
    wctl(64'h18);
    for (j = 0; j < 5; j++) ev(1'b0);
    drain();
    chk({63'h0, buffer_full_irq}, 64'h1);
    wctl(64'h08);
    chk({63'h0, buffer_full_irq}, 64'h0);
    $display("test buffer done");
    @(posedge mclk);
    trap_flag <= 1'b1;
    wctl(64'h03);
    step(1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b1);
    rop(1'b0, `BTR_CTRL_ADDR, {57'h0, ctl}, 1'b0);
    wctl(64'h01);
    step(1'b0, 1'b0, 1'b1);
    wctl(64'h01);
    step(1'b0, 1'b1, 1'b0);
    rop(1'b0, `BTR_CTRL_ADDR, {57'h0, ctl}, 1'b0);
    $display("test stepping done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
